/* File: verilog/slave_i2c_target_port.sv */
// Purpose: slave-only i2c target port with axi4-lite register access
// Assumes: scl/sda sampled by aclk at 250 MHz, no clock stretching
// Notes:   open-drain sda: sda_oe high pulls the line low
`timescale 1ns/1ps
module slave_i2c_target_port
  import slave_i2c_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  input  wire logic [ADDR_W-1:0]                  awaddr,
  input  wire logic                               awvalid,
  output logic                                    awready,
  input  wire logic [slave_i2c_pkg::DATA_W-1:0]   wdata,
  input  wire logic [slave_i2c_pkg::STRB_W-1:0]   wstrb,
  input  wire logic                               wvalid,
  output logic                                    wready,
  output logic [1:0]                              bresp,
  output logic                                    bvalid,
  input  wire logic                               bready,
  input  wire logic [ADDR_W-1:0]                  araddr,
  input  wire logic                               arvalid,
  output logic                                    arready,
  output logic [slave_i2c_pkg::DATA_W-1:0]        rdata,
  output logic [1:0]                              rresp,
  output logic                                    rvalid,
  input  wire logic                               rready,
  input  wire logic                               scl_in,
  input  wire logic                               sda_in,
  output logic                                    sda_out,
  output logic                                    sda_oe,
  output logic                                    irq
);

  import slave_i2c_pkg::*;

  // ==========================================================
  // elaboration checks
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 32");
  end

  typedef struct packed {
    // link side
    link_state_t        st;
    logic [3:0]         bitcnt;
    logic [REG_W-1:0]   shift;
    logic [REG_W-1:0]   own;
    logic               scl_q;
    logic               sda_q;
    logic               sda_out;
    logic               sda_oe;
    // control and status
    logic               ack_en;
    logic               en;
    logic               ie;
    logic               pend;
    logic               tx_mode;
    logic               busy;
    logic               match;
    logic               rx_nack;
    logic [EVT_W-1:0]   evt;
    logic [EVT_W-1:0]   mask;
    logic               irq;
    // register bus
    logic               aw_full;
    logic [ADDR_W-1:0]  aw_addr;
    logic               w_full;
    logic [REG_W-1:0]   w_data;
    logic               w_lane0;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [REG_W-1:0]   rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;

  // ==========================================================
  // pin synchronisers
  pin_sync #(
    .W (2)
  ) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({scl_in, sda_in}),
    .q       (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // word-aligned address compare, low two bits ignored
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        off);
    logic [ADDR_W-1:0] full;
    full    = '0;
    full[7:0] = off;
    addr_is = (a[ADDR_W-1:WORD_LSB] == full[ADDR_W-1:WORD_LSB]);
  endfunction

  // ==========================================================
  // next-state logic
  always_comb begin
    logic             start_c;
    logic             stop_c;
    logic             rise;
    logic             fall;
    logic             pend_set;
    logic             pend_clr;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic             hit;
    logic             wr_go;
    logic [REG_W-1:0] rd_val;
    logic             rd_ok;

    state_next = state_reg;
    pend_set   = 1'b0;
    pend_clr   = 1'b0;
    evt_set    = '0;
    evt_clr    = '0;
    hit        = 1'b0;
    rd_val     = '0;
    rd_ok      = 1'b1;

    // bus conditions from synchronised pins
    start_c = scl_s & state_reg.scl_q & state_reg.sda_q & ~sda_s;
    stop_c  = scl_s & state_reg.scl_q & ~state_reg.sda_q & sda_s;
    rise    = scl_s & ~state_reg.scl_q;
    fall    = ~scl_s & state_reg.scl_q;
    state_next.scl_q   = scl_s;
    state_next.sda_q   = sda_s;
    state_next.sda_out = 1'b0;

    // write address and data accepted in either order
    if (awvalid && state_reg.awready) begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = awaddr;
    end
    if (wvalid && state_reg.wready) begin
      state_next.w_full  = 1'b1;
      state_next.w_data  = wdata[REG_W-1:0];
      state_next.w_lane0 = wstrb[0];
    end
    if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end

    // register write once both halves are held
    wr_go = state_reg.aw_full & state_reg.w_full & ~state_reg.bvalid;
    if (wr_go) begin
      state_next.aw_full = 1'b0;
      state_next.w_full  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = RESP_OKAY;
      if (addr_is(state_reg.aw_addr, OFF_CTRL_STAT)) begin
        if (state_reg.w_lane0) begin
          // status bits 3..0 are not writable
          state_next.ack_en = state_reg.w_data[CS_ACK_EN];
          state_next.en     = state_reg.w_data[CS_ENABLE];
          state_next.ie     = state_reg.w_data[CS_IRQ_EN];
          pend_clr = ~state_reg.w_data[CS_PEND];
        end
      end else if (addr_is(state_reg.aw_addr, OFF_SHIFT)) begin
        if (state_reg.w_lane0 && state_reg.en) begin
          state_next.shift = state_reg.w_data;
        end
      end else if (addr_is(state_reg.aw_addr, OFF_OWN_ADDR)) begin
        if (state_reg.w_lane0 && !state_reg.en) begin
          state_next.own = state_reg.w_data;
        end
      end else if (addr_is(state_reg.aw_addr, OFF_EVT_STATUS)) begin
        if (state_reg.w_lane0) begin
          evt_clr = state_reg.w_data[EVT_W-1:0];
        end
      end else if (addr_is(state_reg.aw_addr, OFF_EVT_MASK)) begin
        if (state_reg.w_lane0) begin
          state_next.mask = state_reg.w_data[EVT_W-1:0];
        end
      end else begin
        state_next.bresp = RESP_SLVERR;
      end
    end

    // bus busy tracking, independent of enable
    if (start_c) begin
      state_next.busy = 1'b1;
    end else if (stop_c) begin
      state_next.busy = 1'b0;
    end

    // link state machine; hardware shifting wins over software
    case (state_reg.st)
      st_addr: begin
        if (rise) begin
          state_next.shift  = {state_reg.shift[REG_W-2:0], sda_s};
          state_next.bitcnt = state_reg.bitcnt + 4'h1;
        end else if (fall && state_reg.bitcnt == BYTE_BITS) begin
          state_next.bitcnt = '0;
          hit = (state_reg.shift[REG_W-1:1] == state_reg.own[REG_W-1:1]) ||
                (state_reg.shift[REG_W-1:1] == GENERAL_CALL);
          if (hit) begin
            state_next.match   = 1'b1;
            pend_set           = 1'b1;
            evt_set[EV_MATCH]  = 1'b1;
            state_next.tx_mode = state_reg.shift[0];
            state_next.sda_oe  = state_reg.ack_en;
            state_next.st      = st_addr_ack;
          end else begin
            state_next.st      = st_skip;
          end
        end
      end
      st_addr_ack: begin
        if (fall) begin
          if (state_reg.tx_mode) begin
            state_next.sda_oe = ~state_reg.shift[REG_W-1];
            state_next.st     = st_tx;
          end else begin
            state_next.sda_oe = 1'b0;
            state_next.st     = st_rx;
          end
        end
      end
      st_rx: begin
        if (rise) begin
          state_next.shift  = {state_reg.shift[REG_W-2:0], sda_s};
          state_next.bitcnt = state_reg.bitcnt + 4'h1;
        end else if (fall && state_reg.bitcnt == BYTE_BITS) begin
          state_next.bitcnt = '0;
          pend_set          = 1'b1;
          evt_set[EV_BYTE]  = 1'b1;
          state_next.sda_oe = state_reg.ack_en;
          state_next.st     = st_rx_ack;
        end
      end
      st_rx_ack: begin
        if (fall) begin
          state_next.sda_oe = 1'b0;
          state_next.st     = st_rx;
        end
      end
      st_tx: begin
        // bus bits shift back in so the register shows what was sent
        if (rise) begin
          state_next.shift  = {state_reg.shift[REG_W-2:0], sda_s};
          state_next.bitcnt = state_reg.bitcnt + 4'h1;
        end else if (fall) begin
          if (state_reg.bitcnt == BYTE_BITS) begin
            state_next.sda_oe = 1'b0;
            state_next.st     = st_tx_ack;
          end else begin
            state_next.sda_oe = ~state_reg.shift[REG_W-1];
          end
        end
      end
      st_tx_ack: begin
        if (rise) begin
          state_next.rx_nack = sda_s;
          pend_set           = 1'b1;
          evt_set[EV_BYTE]   = 1'b1;
        end else if (fall) begin
          state_next.bitcnt = '0;
          if (state_reg.rx_nack) begin
            state_next.sda_oe = 1'b0;
            state_next.st     = st_skip;
          end else begin
            state_next.sda_oe = ~state_reg.shift[REG_W-1];
            state_next.st     = st_tx;
          end
        end
      end
      st_idle, st_skip: begin
        state_next.sda_oe = 1'b0;
      end
      default: begin
        state_next.sda_oe = 1'b0;
        state_next.st     = st_idle;
      end
    endcase

    // start and stop override any bit in progress
    if (start_c) begin
      state_next.match  = 1'b0;
      state_next.sda_oe = 1'b0;
      state_next.bitcnt = '0;
      state_next.st     = st_addr;
    end else if (stop_c) begin
      state_next.match  = 1'b0;
      state_next.sda_oe = 1'b0;
      state_next.st     = st_idle;
      evt_set[EV_STOP]  = 1'b1;
    end

    // disabled port stays off the bus
    if (!state_reg.en) begin
      state_next.st      = st_idle;
      state_next.sda_oe  = 1'b0;
      state_next.tx_mode = 1'b0;
      evt_set            = '0;
      pend_set           = 1'b0;
    end

    // pending flag: set wins over a software clear
    if (pend_clr) begin
      state_next.pend = 1'b0;
    end
    if (pend_set) begin
      state_next.pend = 1'b1;
    end
    if (!state_next.en) begin
      state_next.pend = 1'b0;
    end

    // sticky events, set wins over write-one-to-clear
    state_next.evt = (state_reg.evt & ~evt_clr) | evt_set;

    // one level request for both interrupt paths
    state_next.irq = (state_reg.pend & state_reg.ie) |
                     (|(state_reg.evt & state_reg.mask));

    // register read, answered one cycle after acceptance
    if (state_reg.rvalid && rready) begin
      state_next.rvalid  = 1'b0;
      state_next.arready = 1'b1;
    end
    if (arvalid && state_reg.arready) begin
      if (addr_is(araddr, OFF_CTRL_STAT)) begin
        rd_val = {state_reg.ack_en, state_reg.en, state_reg.ie,
                  state_reg.pend, state_reg.tx_mode, state_reg.busy,
                  state_reg.match, state_reg.rx_nack};
      end else if (addr_is(araddr, OFF_SHIFT)) begin
        rd_val = state_reg.shift;
      end else if (addr_is(araddr, OFF_OWN_ADDR)) begin
        rd_val = {state_reg.own[REG_W-1:1], 1'b0};
      end else if (addr_is(araddr, OFF_EVT_STATUS)) begin
        rd_val[EVT_W-1:0] = state_reg.evt;
      end else if (addr_is(araddr, OFF_EVT_MASK)) begin
        rd_val[EVT_W-1:0] = state_reg.mask;
      end else begin
        rd_ok = 1'b0;
      end
      state_next.rdata   = rd_val;
      state_next.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
      state_next.rvalid  = 1'b1;
      state_next.arready = 1'b0;
    end

    // ready flags registered so the ports come from flops
    state_next.awready = ~state_next.aw_full;
    state_next.wready  = ~state_next.w_full;
    // read address open whenever no read data waits, so reads work after reset
    state_next.arready = ~state_next.rvalid;
  end

  // ==========================================================
  // state register; all-zero reset clears match and pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign awready = state_reg.awready;
  assign wready  = state_reg.wready;
  assign bvalid  = state_reg.bvalid;
  assign bresp   = state_reg.bresp;
  assign arready = state_reg.arready;
  assign rvalid  = state_reg.rvalid;
  assign rresp   = state_reg.rresp;
  assign rdata   = {{(DATA_W-REG_W){1'b0}}, state_reg.rdata};
  assign sda_out = state_reg.sda_out;
  assign sda_oe  = state_reg.sda_oe;
  assign irq     = state_reg.irq;

endmodule // slave_i2c_target_port

/* File: verilog/slave_i2c_pkg.sv */
// Purpose: shared constants for the slave-only i2c target port
// Assumes: 32-bit axi4-lite register bus, 8-bit register contents
// Notes:   byte addresses below, one aligned word per register
package slave_i2c_pkg;

  // ==========================================================
  // bus widths and responses
  localparam int          DATA_W     = 32;
  localparam int          STRB_W     = DATA_W / 8;
  localparam int          REG_W      = 8;
  localparam int          WORD_LSB   = 2;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0]  OFF_EVT_STATUS = 8'hE8;
  localparam logic [7:0]  OFF_EVT_MASK   = 8'hEC;
  localparam logic [7:0]  OFF_CTRL_STAT  = 8'hF0;
  localparam logic [7:0]  OFF_SHIFT      = 8'hF4;
  localparam logic [7:0]  OFF_OWN_ADDR   = 8'hF8;

  // ==========================================================
  // slave_control_status bit positions
  localparam int          CS_ACK_EN  = 7;
  localparam int          CS_ENABLE  = 6;
  localparam int          CS_IRQ_EN  = 5;
  localparam int          CS_PEND    = 4;
  localparam int          CS_TX_MODE = 3;
  localparam int          CS_BUSY    = 2;
  localparam int          CS_MATCH   = 1;
  localparam int          CS_NACK    = 0;

  // ==========================================================
  // event status bits (write one to clear)
  localparam int          EVT_W      = 3;
  localparam int          EV_BYTE    = 0;
  localparam int          EV_MATCH   = 1;
  localparam int          EV_STOP    = 2;

  // ==========================================================
  // link framing and reset values
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam logic [6:0]  GENERAL_CALL = 7'h00;
  localparam logic [7:0]  OWN_ADDR_RST = 8'h00;
  localparam logic [7:0]  SHIFT_RST    = 8'h00;

  // ==========================================================
  // link state, gray coded along the usual path
  typedef enum logic [2:0] {
    st_idle     = 3'h0,
    st_addr     = 3'h1,
    st_addr_ack = 3'h3,
    st_rx       = 3'h2,
    st_rx_ack   = 3'h6,
    st_tx       = 3'h7,
    st_tx_ack   = 3'h5,
    st_skip     = 3'h4
  } link_state_t;

endpackage

/* File: verilog/pin_sync.sv */
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: inputs are quasi-static relative to aclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t sync_reg;
  sync_t sync_next;

  // ==========================================================
  // next state: plain shift through two stages
  always_comb begin
    sync_next.s1 = d;
    sync_next.s2 = sync_reg.s1;
  end

  // reset to idle-high bus level would hide a stuck pin, so zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.s2;

endmodule // pin_sync

/* File: testbench/port_monitor.sv */
// Purpose: concurrent checks on the target port pins
// Assumes: one clock domain, synchronous active-low reset
// Notes:   attached by bind, sees top-level ports only
`timescale 1ns/1ps
module port_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        scl_in,
  input wire logic        sda_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ======
  // register bus: answers come within a fixed bound and stand
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_resp_soon;
    ##[1:3] bvalid;
  endsequence
  a_write_answered: assert property (s_wr_taken |-> s_resp_soon)
    else $error("write response missing");
  a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_read_answered: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_rdata_narrow: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_aw_once: assert property (awvalid && awready |=> !awready)
    else $error("write address taken twice");
  a_ready_back: assert property ($rose(aresetn) |=> awready && wready)
    else $error("write channel not ready after reset");

  // ======
  // link: sda only moves while scl is low, so no false start or stop
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("sda moved while scl high");
endmodule // port_monitor

bind slave_i2c_target_port port_monitor #(.ADDR_W(ADDR_W)) port_monitor_i (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .scl_in(scl_in), .sda_oe(sda_oe));

/* File: testbench/i2c_host.sv */
// Purpose: behavioural bus master driving scl and pulling sda
// Assumes: 32 ns bit period, pull-ups on both lines
// Notes:   scl stands high between frames
`timescale 1ns/1ps
module i2c_host (
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  localparam int QTR = 8;

  // ======
  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // start or repeated start: sda falls while scl high
  // trailing quarter lets the synchronised port register it before a read
  task automatic start_cond();
    #QTR sda_pull <= 1'b0;
    #QTR scl <= 1'b1;
    #QTR sda_pull <= 1'b1;
    #QTR scl <= 1'b0;
    #QTR;
  endtask

  // stop: sda rises while scl high
  task automatic stop_cond();
    #QTR sda_pull <= 1'b1;
    #QTR scl <= 1'b1;
    #QTR sda_pull <= 1'b0;
    #QTR;
  endtask

  // data changes only while scl low; sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    #QTR sda_pull <= !b;
    #QTR scl <= 1'b1;
    #(2*QTR-1) s = sda_line;
    #1 scl <= 1'b0;
  endtask

  task automatic send8(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s); // msb first
  endtask

  // eight bits then a released ack slot
  task automatic write_byte(input logic [7:0] d, output logic nack);
    send8(d);
    bit_io(1'b1, nack);
  endtask

  task automatic read_byte(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!give_ack, s);
  endtask
endmodule // i2c_host

/* File: testbench/tb.sv */
// Purpose: self-checking bench for the slave i2c target port
// Assumes: i2c_host drives the link, bench is the bus master
// Notes:   a read that is never accepted ends in the watchdog
`timescale 1ns/1ps
module tb;
  import slave_i2c_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        sda_out, sda_oe, irq, scl, sda_pull, nack;
  logic [7:0]  v;
  wire         sda_line = !(sda_oe || sda_pull);
  int          n_fail = 0;
  int          samples_checked = 0;

  slave_i2c_target_port slave_i2c_target_port_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  i2c_host i2c_host_i (.sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  // ======
  // verdict and compares
  task automatic end_sim();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_bit(input string what, input logic e, input logic g);
    chk_byte(what, {7'h0, e}, {7'h0, g});
  endtask

  // ======
  // register bus master; unmapped offsets expect an error response
  function automatic logic [1:0] resp_for(input logic [7:0] a);
    return (a inside {OFF_EVT_STATUS, OFF_EVT_MASK, OFF_CTRL_STAT, OFF_SHIFT, OFF_OWN_ADDR})
      ? RESP_OKAY : RESP_SLVERR;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk_byte("write response", {6'h0, resp_for(a)}, {6'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    d = rdata[7:0];
    chk_byte("read response", {6'h0, resp_for(a)}, {6'h0, rresp});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    if (resp_for(a) === RESP_OKAY) chk_byte($sformatf("reg %h", a), e, d);
  endtask

  // ======
  // reset values, write gating and read-only bits
  task automatic t_regs();
    rd_chk(OFF_CTRL_STAT, 8'h00);
    wr(OFF_SHIFT, 8'h33);
    rd_chk(OFF_SHIFT, 8'h00);
    wr(OFF_OWN_ADDR, 8'h5B);
    rd_chk(OFF_OWN_ADDR, 8'h5A);
    wr(OFF_CTRL_STAT, 8'hDF);
    rd_chk(OFF_CTRL_STAT, 8'hC0);
    wr(OFF_OWN_ADDR, 8'h22);
    rd_chk(OFF_OWN_ADDR, 8'h5A);
    wr(OFF_SHIFT, 8'hA5);
    rd_chk(OFF_SHIFT, 8'hA5);
    wstrb <= 4'h0;
    wr(OFF_SHIFT, 8'h11);
    wstrb <= 4'hF;
    rd_chk(OFF_SHIFT, 8'hA5);
    wr(8'h04, 8'h01);
    rd_chk(8'h04, 8'h00);
  endtask

  // write transfer: address match, data byte, stop event interrupt
  task automatic t_rx();
    wr(OFF_CTRL_STAT, 8'hE0);
    i2c_host_i.start_cond();
    rd_chk(OFF_CTRL_STAT, 8'hE4);
    i2c_host_i.write_byte(8'h5A, nack);
    chk_bit("address ack", 1'b0, nack);
    chk_bit("sda out", 1'b0, sda_out);
    rd_chk(OFF_CTRL_STAT, 8'hF6);
    chk_bit("irq", 1'b1, irq);
    wr(OFF_CTRL_STAT, 8'hE0);
    rd_chk(OFF_CTRL_STAT, 8'hE6);
    chk_bit("irq", 1'b0, irq);
    i2c_host_i.write_byte(8'h3C, nack);
    chk_bit("data ack", 1'b0, nack);
    rd_chk(OFF_SHIFT, 8'h3C);
    rd_chk(OFF_CTRL_STAT, 8'hF6);
    wr(OFF_CTRL_STAT, 8'hE0);
    wr(OFF_EVT_MASK, 8'h04);
    i2c_host_i.stop_cond();
    repeat (6) @(posedge aclk);
    chk_bit("irq", 1'b1, irq);
    rd_chk(OFF_CTRL_STAT, 8'hE0);
    rd_chk(OFF_EVT_STATUS, 8'h07);
    wr(OFF_EVT_STATUS, 8'h07);
    rd_chk(OFF_EVT_STATUS, 8'h00);
    chk_bit("irq", 1'b0, irq);
    wr(OFF_EVT_MASK, 8'h00);
  endtask

  // foreign address, then own address with ack generation off
  task automatic t_noack();
    i2c_host_i.start_cond();
    i2c_host_i.write_byte(8'h40, nack);
    chk_bit("foreign ack", 1'b1, nack);
    rd_chk(OFF_CTRL_STAT, 8'hE4);
    i2c_host_i.stop_cond();
    wr(OFF_CTRL_STAT, 8'h60);
    i2c_host_i.start_cond();
    i2c_host_i.write_byte(8'h5A, nack);
    chk_bit("ack off", 1'b1, nack);
    rd_chk(OFF_CTRL_STAT, 8'h76);
    i2c_host_i.stop_cond();
  endtask

  // read transfer, interrupt disabled; shift loaded during address ack
  task automatic t_tx();
    wr(OFF_CTRL_STAT, 8'hC0);
    i2c_host_i.start_cond();
    i2c_host_i.send8(8'h5B);
    fork
      i2c_host_i.bit_io(1'b1, nack);
      begin
        repeat (3) @(posedge aclk);
        wr(OFF_SHIFT, 8'h96);
      end
    join
    chk_bit("read address ack", 1'b0, nack);
    i2c_host_i.read_byte(1'b1, v);
    chk_byte("sent byte", 8'h96, v);
    rd_chk(OFF_CTRL_STAT, 8'hDE);
    chk_bit("irq", 1'b0, irq);
    i2c_host_i.read_byte(1'b0, v);
    chk_byte("resent byte", 8'h96, v);
    rd_chk(OFF_CTRL_STAT, 8'hDF);
    i2c_host_i.start_cond();
    rd(OFF_CTRL_STAT, v);
    chk_bit("match", 1'b0, v[CS_MATCH]);
    chk_bit("busy", 1'b1, v[CS_BUSY]);
    i2c_host_i.stop_cond();
  endtask

  // disabled module: pending forced low, no ack
  task automatic t_off();
    wr(OFF_CTRL_STAT, 8'h80);
    rd(OFF_CTRL_STAT, v);
    chk_bit("pending", 1'b0, v[CS_PEND]);
    i2c_host_i.start_cond();
    i2c_host_i.write_byte(8'h5A, nack);
    chk_bit("disabled ack", 1'b1, nack);
    rd(OFF_CTRL_STAT, v);
    chk_bit("pending", 1'b0, v[CS_PEND]);
    chk_bit("busy", 1'b1, v[CS_BUSY]);
    i2c_host_i.stop_cond();
  endtask

  // ======
  // clock, watchdog and main sequence
  always #2 aclk = ~aclk;

  initial begin
    #60000;
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_rx();
    t_noack();
    t_tx();
    t_off();
    end_sim();
  end
endmodule // tb
